/* File: rtl/two_speed_clock_startup.sv */
// Purpose: Two-speed start-up and oscillator switching delay control
// Assumes: Sleep and wake are one-cycle pulses from the core
// Notes: Output is clock selection, not the clock itself
`timescale 1ns/1ps
module two_speed_clock_startup #(
   parameter int PLL_LOCK_CYC = tsc_pkg::PLL_LOCK_CYC,
   parameter int WARMUP_CYC = tsc_pkg::WARMUP_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic int_osc_i,
   input wire logic ext_osc_i,
   input wire logic int_ext_switchover_cfg_i,
   input wire logic [1:0] system_clock_select_i,
   input wire logic [2:0] osc_mode_i,
   input wire logic [3:0] internal_freq_select_i,
   input wire logic failsafe_clock_monitor_i,
   input wire logic powerup_timer_en_i,
   input wire logic powerup_timer_done_i,
   input wire logic sleep_i,
   input wire logic wake_i,
   input wire logic switch_req_i,
   input wire logic [2:0] switch_from_i,
   input wire logic [2:0] switch_to_i,
   input wire logic pll_enable_i,
   input wire logic pll_range_ok_i,
   output logic startup_done_status_o,
   output logic sys_clk_ext_o,
   output logic sys_clk_hold_o,
   output logic two_speed_active_o,
   output logic [3:0] internal_freq_o,
   output logic switch_busy_o,
   output logic switch_done_o,
   output logic pll_locked_o
);
   typedef enum logic [2:0] {
      TS_POWERUP_TIMER, TS_IDLE, TS_COUNT, TS_WAIT_INT, TS_HOLD, TS_EXT, TS_SLEEP
   } ts_state_e;
   typedef enum logic [1:0] {SW_IDLE, SW_WAIT_INT, SW_EXT, SW_CLK} sw_state_e;
   typedef struct packed {
      ts_state_e fsm;
      logic [tsc_pkg::OST_W-1:0] osc_startup_counter;
      logic status;
      logic sel_ext;
      logic hold;
      logic active;
      logic [3:0] freq;
      sw_state_e sw;
      logic [tsc_pkg::CNT_W-1:0] sw_cnt;
      logic sw_busy;
      logic sw_done;
      logic pll_busy;
      logic pll_locked;
      logic [tsc_pkg::CNT_W-1:0] pll_cnt;
   } state_s;

   state_s q;
   state_s d;
   logic xtal_mode;
   logic ts_enable;
   logic to_int;
   logic from_sleep;
   tsc_pkg::clk_src_e src_from;
   tsc_pkg::clk_src_e src_to;

   osc_edge_if int_edge ();
   osc_edge_if ext_edge ();

   osc_fall_detect u_int_fall (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .osc_i(int_osc_i),
      .edge_o(int_edge)
   );
   osc_fall_detect u_ext_fall (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .osc_i(ext_osc_i),
      .edge_o(ext_edge)
   );

   assign src_from = tsc_pkg::clk_src_e'(switch_from_i);
   assign src_to = tsc_pkg::clk_src_e'(switch_to_i);
   assign from_sleep = (src_from == tsc_pkg::SRC_SLEEP_POR);
   assign to_int = (src_to == tsc_pkg::SRC_LOW_INT) || (src_to == tsc_pkg::SRC_MID_INT) ||
                   (src_to == tsc_pkg::SRC_HIGH_INT);

   assign xtal_mode = (osc_mode_i == tsc_pkg::MODE_LOW_POWER_XTAL) ||
                      (osc_mode_i == tsc_pkg::MODE_CRYSTAL) ||
                      (osc_mode_i == tsc_pkg::MODE_HIGH_SPEED_XTAL);
   // enable terms, fail-safe overrides switchover bit
   assign ts_enable = xtal_mode && (system_clock_select_i == tsc_pkg::SYS_SEL_PRIMARY) &&
                      (int_ext_switchover_cfg_i || failsafe_clock_monitor_i);

   always_comb begin
      d = q;
      d.sw_done = 1'b0;
      // internal frequency follows select while internal
      if (!q.sel_ext) begin
         d.freq = internal_freq_select_i;
      end
      unique case (q.fsm)
         TS_POWERUP_TIMER: begin
            if (!powerup_timer_en_i || powerup_timer_done_i) begin
               d.osc_startup_counter = '0;
               d.fsm = ts_enable ? TS_COUNT : TS_IDLE;
               d.active = ts_enable;
            end
         end
         TS_IDLE: begin
            d.active = 1'b0;
         end
         TS_COUNT: begin
            if (q.osc_startup_counter == tsc_pkg::OST_LIMIT) begin
               d.fsm = TS_WAIT_INT;
            end else if (ext_edge.fall) begin
               d.osc_startup_counter = q.osc_startup_counter + 11'h001;
            end
         end
         TS_WAIT_INT: begin
            // status set on internal falling edge
            if (int_edge.fall) begin
               d.status = 1'b1;
               d.hold = 1'b1;
               d.fsm = TS_HOLD;
            end
         end
         TS_HOLD: begin
            // clock held low until external falling edge
            if (ext_edge.fall) begin
               d.hold = 1'b0;
               d.sel_ext = 1'b1;
               d.active = 1'b0;
               d.fsm = TS_EXT;
            end
         end
         TS_EXT: begin
            d.sel_ext = 1'b1;
         end
         TS_SLEEP: begin
            // wake restarts count with status clear
            if (wake_i) begin
               d.osc_startup_counter = '0;
               d.status = 1'b0;
               d.sel_ext = 1'b0;
               d.fsm = ts_enable ? TS_COUNT : TS_IDLE;
               d.active = ts_enable;
            end
         end
      endcase
      // sleep aborts start-up and clears status, except in TS_EXT where status and external select are kept
      if (sleep_i && (q.fsm != TS_SLEEP)) begin
         d.fsm = TS_SLEEP;
         d.active = 1'b0;
         d.hold = 1'b0;
         if (q.fsm != TS_EXT) begin
            d.status = 1'b0;
            d.sel_ext = 1'b0;
         end
      end

      unique case (q.sw)
         SW_IDLE: begin
            if (switch_req_i) begin
               if (to_int && from_sleep) begin
                  d.sw = SW_CLK;
                  d.sw_cnt = tsc_pkg::CNT_W'(WARMUP_CYC);
               end else if (src_to == tsc_pkg::SRC_MID_INT || src_to == tsc_pkg::SRC_HIGH_INT) begin
                  d.sw = SW_CLK;
                  d.sw_cnt = tsc_pkg::CNT_W'(tsc_pkg::TWO_US_CYC);
               end else if (src_to == tsc_pkg::SRC_EXT_RESCAP && from_sleep) begin
                  d.sw = SW_EXT;
                  d.sw_cnt = tsc_pkg::ECRC_WAKE_CYC;
               end else if (src_to == tsc_pkg::SRC_LOW_INT ||
                            (src_to == tsc_pkg::SRC_EXT_RESCAP &&
                             src_from == tsc_pkg::SRC_LOW_INT)) begin
                  // one internal then one external cycle
                  d.sw = SW_WAIT_INT;
                  d.sw_cnt = tsc_pkg::EACH_CYC;
               end else if (src_to == tsc_pkg::SRC_XTAL || src_to == tsc_pkg::SRC_TIMER_OSC) begin
                  // full start-up count on new oscillator
                  d.sw = SW_EXT;
                  d.sw_cnt = tsc_pkg::XTAL_SWITCH_CYC;
               end else begin
                  d.sw = SW_EXT;
                  d.sw_cnt = tsc_pkg::EACH_CYC;
               end
            end
         end
         SW_WAIT_INT: begin
            if (int_edge.fall) begin
               d.sw = SW_EXT;
            end
         end
         SW_EXT: begin
            if (ext_edge.fall) begin
               d.sw_cnt = q.sw_cnt - 20'h00001;
               if (q.sw_cnt <= 20'h00001) begin
                  d.sw = SW_IDLE;
                  d.sw_done = 1'b1;
               end
            end
         end
         SW_CLK: begin
            d.sw_cnt = q.sw_cnt - 20'h00001;
            if (q.sw_cnt <= 20'h00001) begin
               d.sw = SW_IDLE;
               d.sw_done = 1'b1;
            end
         end
      endcase

      if (!pll_enable_i) begin
         d.pll_busy = 1'b0;
         d.pll_locked = 1'b0;
      end else if (q.pll_busy) begin
         d.pll_cnt = q.pll_cnt - 20'h00001;
         if (q.pll_cnt <= 20'h00001) begin
            d.pll_busy = 1'b0;
            d.pll_locked = 1'b1;
         end
      end else if (!q.pll_locked) begin
         // Out of range result has no documented delay, taken as immediate
         d.pll_busy = pll_range_ok_i;
         d.pll_locked = !pll_range_ok_i;
         d.pll_cnt = tsc_pkg::CNT_W'(PLL_LOCK_CYC);
      end
      // Busy kept in a flop so the output carries no decode glitch
      d.sw_busy = (d.sw != SW_IDLE);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign startup_done_status_o = q.status;
   assign sys_clk_ext_o = q.sel_ext;
   assign sys_clk_hold_o = q.hold;
   assign two_speed_active_o = q.active;
   assign internal_freq_o = q.freq;
   assign switch_busy_o = q.sw_busy;
   assign switch_done_o = q.sw_done;
   assign pll_locked_o = q.pll_locked;

   localparam int A_TWO_US = tsc_pkg::TWO_US_CYC;
   localparam int A_TWO_US_MAX = tsc_pkg::TWO_US_CYC + 1;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   a_count_full: assert property ($rose(q.status) |-> q.osc_startup_counter == tsc_pkg::OST_LIMIT)
      else $error("done status set before full start-up count");
   a_mode_gate: assert property ($rose(two_speed_active_o) |-> $past(xtal_mode))
      else $error("two-speed start-up without crystal mode");
   a_enable_terms: assert property ((q.fsm == TS_POWERUP_TIMER) && !powerup_timer_en_i && !sleep_i |=>
      (q.fsm == TS_COUNT) == $past(ts_enable)) else $error("start-up enable mismatch");
   a_sleep_abort: assert property (sleep_i && (q.fsm == TS_COUNT || q.fsm == TS_WAIT_INT) |=>
      q.fsm == TS_SLEEP && !startup_done_status_o) else $error("sleep did not abort");
   a_status_on_fall: assert property ($rose(startup_done_status_o) |-> $past(int_edge.fall) &&
      $past(q.fsm == TS_WAIT_INT)) else $error("status set off internal edge");
   a_hold_then_ext: assert property ($rose(sys_clk_ext_o) |-> $past(sys_clk_hold_o) &&
      $past(ext_edge.fall) && !sys_clk_hold_o) else $error("switch without hold and edge");
   a_ext_has_status: assert property (sys_clk_ext_o |-> startup_done_status_o)
      else $error("external clock without done status");
   a_wake_restart: assert property (wake_i && q.fsm == TS_SLEEP && !sleep_i |=>
      q.osc_startup_counter == '0 && !startup_done_status_o) else $error("wake kept state");
   a_freq_follow: assert property (!sys_clk_ext_o && (q.fsm == TS_COUNT) |=>
      internal_freq_o == $past(internal_freq_select_i)) else $error("frequency not tracked");
   a_fast_delay: assert property ((q.sw == SW_IDLE) && switch_req_i && !from_sleep &&
      (src_to == tsc_pkg::SRC_HIGH_INT) |=> !switch_done_o[*8] ##[1:A_TWO_US_MAX] switch_done_o)
      else $error("fast internal delay wrong");
   a_pll_wait: assert property ($rose(q.pll_busy) |-> !pll_locked_o[*8])
      else $error("pll locked too early");
   a_busy_until_done: assert property ($fell(switch_busy_o) |-> switch_done_o)
      else $error("switch ended without done pulse");
   a_xtal_delay: assert property ((q.sw == SW_IDLE) && switch_req_i &&
      (src_to == tsc_pkg::SRC_XTAL) |=> switch_busy_o[*8])
      else $error("crystal switch delay too short");

   c_full_startup: cover property ($rose(sys_clk_ext_o));
   c_sleep_abort: cover property (q.fsm == TS_COUNT ##1 q.fsm == TS_SLEEP);
   c_fast_switch: cover property (q.sw == SW_CLK ##1 switch_done_o);
   c_ext_switch: cover property (q.sw == SW_EXT ##1 switch_done_o);
   c_pll_lock: cover property ($rose(pll_locked_o));
endmodule

/* File: rtl/tsc_pkg.sv */
// Purpose: Constants shared by the two-speed clock start-up block
// Assumes: 250 MHz system clock, oscillator levels synchronous to it
// Notes: Mode codes and source codes are local encodings
// Function
// - Crystal modes need 1024 external cycles counted before external clock use
// - Non-crystal oscillator modes disable two-speed start-up entirely
// - Count reaching 1024 before sleep sets done status, moves to external
// - Sleep during start-up aborts the count and keeps done status clear
// - Enable needs switchover bit 1, clock select 00, crystal mode
// - Start-up entered after power-on plus power-up timer, and after wake
// - Fail-safe monitor enabled forces two-speed start-up on regardless of switchover
// - Start runs on internal oscillator at the four-bit selected frequency
// - After count timeout wait internal falling edge, then set done status
// - Hold system clock low until external falling edge, then switch
// - Done status tells external source versus internal oscillator running
// - Sleep or power-on to external clock or RC mode: 2 cycles
// - Low-frequency internal to or from external/RC: one cycle of each
// - Any source to mid or high internal oscillator: about 2 us
// - To timer oscillator or crystal modes: 1024 counted clock cycles
// - PLL inactive to active at 16-32 MHz: about 2 ms lock
// - Internal oscillator started from sleep or power-on needs warm-up delay
package tsc_pkg;
   localparam logic [2:0] MODE_LOW_POWER_XTAL = 3'h0;
   localparam logic [2:0] MODE_CRYSTAL = 3'h1;
   localparam logic [2:0] MODE_HIGH_SPEED_XTAL = 3'h2;
   localparam logic [2:0] MODE_EXT_CLOCK = 3'h3;
   localparam logic [2:0] MODE_RES_CAP = 3'h4;
   localparam logic [1:0] SYS_SEL_PRIMARY = 2'h0;
   localparam int OST_W = 11;
   localparam int CNT_W = 20;
   localparam logic [10:0] OST_LIMIT = 11'h400;
   localparam logic [3:0] FREQ_RST = 4'h0;
   localparam logic [19:0] ECRC_WAKE_CYC = 20'h00002;
   localparam logic [19:0] EACH_CYC = 20'h00001;
   localparam logic [19:0] XTAL_SWITCH_CYC = 20'h00400;
   localparam int CLK_PERIOD_NS = 4;
   localparam int TWO_US_NS = 2000;
   localparam int TWO_US_CYC = (TWO_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PLL_LOCK_NS = 2000000;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WARMUP_NS = 2000;
   localparam int WARMUP_CYC = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      SRC_SLEEP_POR, SRC_LOW_INT, SRC_MID_INT, SRC_HIGH_INT,
      SRC_EXT_RESCAP, SRC_XTAL, SRC_TIMER_OSC
   } clk_src_e;
endpackage

/* File: rtl/osc_edge_if.sv */
// Purpose: Carries a sampled oscillator level and its falling edge
// Assumes: One detector drives, the start-up controller listens
// Notes: Both signals come from flip-flops
`timescale 1ns/1ps
interface osc_edge_if;
   logic level;
   logic fall;
   modport src (output level, output fall);
   modport dst (input level, input fall);
endinterface

/* File: rtl/osc_fall_detect.sv */
// Purpose: Falling edge detector for one oscillator input
// Assumes: Oscillator input already synchronous to clk_i
// Notes: Oscillator must stay below half the system clock rate
`timescale 1ns/1ps
module osc_fall_detect (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic osc_i,
   osc_edge_if.src edge_o
);
   typedef struct packed {
      logic level;
      logic fall;
   } det_s;
   det_s q;
   det_s d;
   always_comb begin
      d = q;
      d.level = osc_i;
      d.fall = q.level & ~osc_i;
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign edge_o.level = q.level;
   assign edge_o.fall = q.fall;
endmodule

/* File: verification/xtal_osc_model.sv */
// Purpose: Crystal oscillator at the far side of the start-up block
// Assumes: Half period in system clock cycles, at least 2
// Notes: Rests low while stopped, since a crystal does not swing in sleep
`timescale 1ns/1ps
module xtal_osc_model #(
   parameter int HALF_CYC = 4
) (
   input wire logic clk_i,
   input wire logic run_i,
   output logic osc_o
);
   int cnt_q = 0;
   initial osc_o = 1'b0;
   always @(posedge clk_i) begin
      if (!run_i) begin
         cnt_q <= 0;
         osc_o <= 1'b0;
      end else if (cnt_q == HALF_CYC - 1) begin
         cnt_q <= 0;
         osc_o <= !osc_o;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule

/* File: verification/tb_two_speed_clock_startup.sv */
// Purpose: Self-checking bench for the two-speed start-up block
// Assumes: Crystal half period 4 clocks, internal oscillator half period 3
// Notes: Delays are given a one- or two-step tolerance where edge counting is loose
`timescale 1ns/1ps
module tb_two_speed_clock_startup;
   localparam int pll_cyc = 20;
   localparam int warm = 500;
   logic clk_i = 1'b0, srst_i = 1'b1, int_osc = 1'b0, ext_run = 1'b1, ext_osc;
   logic cfg = 1'b1, fsm = 1'b0, powerup_timer_en = 1'b0, powerup_timer_done = 1'b0;
   logic [1:0] sys_sel = 2'h0;
   logic [2:0] osc_mode = 3'h1, sw_from = 3'h0, sw_to = 3'h0;
   logic [3:0] freq_sel = 4'h0, freq_o;
   logic sleep = 1'b0, wake = 1'b0, sw_req = 1'b0, pll_en = 1'b0, pll_ok = 1'b0;
   logic status, clk_ext, clk_hold, ts_active, busy, done, locked, ext_prev = 1'b0;
   logic [15:0] seed = 16'h7c10;
   int miscompares = 0, cmp_count = 0, falls = 0, int_cnt = 0, c;
   // From, to, kind (1 = external edges), expected count
   int sw_tab[7][4] = '{'{1, 3, 0, tsc_pkg::TWO_US_CYC}, '{5, 2, 0, tsc_pkg::TWO_US_CYC},
      '{0, 3, 0, warm}, '{0, 4, 1, 2}, '{2, 5, 1, 1024}, '{0, 6, 1, 1024}, '{1, 4, 1, 1}};

   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      int_cnt <= (int_cnt == 2) ? 0 : int_cnt + 1;
      if (int_cnt == 2) int_osc <= ~int_osc;
      ext_prev <= ext_osc;
      if (ext_prev && !ext_osc) falls <= falls + 1;
   end

   xtal_osc_model xtal_osc_model_inst (.clk_i(clk_i), .run_i(ext_run), .osc_o(ext_osc));
   two_speed_clock_startup #(.PLL_LOCK_CYC(pll_cyc), .WARMUP_CYC(warm))
      two_speed_clock_startup_inst (
      .clk_i(clk_i), .srst_i(srst_i), .int_osc_i(int_osc), .ext_osc_i(ext_osc),
      .int_ext_switchover_cfg_i(cfg), .system_clock_select_i(sys_sel),
      .osc_mode_i(osc_mode), .internal_freq_select_i(freq_sel),
      .failsafe_clock_monitor_i(fsm), .powerup_timer_en_i(powerup_timer_en),
      .powerup_timer_done_i(powerup_timer_done), .sleep_i(sleep), .wake_i(wake),
      .switch_req_i(sw_req), .switch_from_i(sw_from), .switch_to_i(sw_to),
      .pll_enable_i(pll_en), .pll_range_ok_i(pll_ok), .startup_done_status_o(status),
      .sys_clk_ext_o(clk_ext), .sys_clk_hold_o(clk_hold), .two_speed_active_o(ts_active),
      .internal_freq_o(freq_o), .switch_busy_o(busy), .switch_done_o(done),
      .pll_locked_o(locked));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, lo);
      end
   endtask

   // Bounded wait: 0 status, 1 external clock, 2 switch done, 3 lock
   task automatic wait_for(input int which, input int bound, output int n);
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < bound) begin
         step(1);
         n++;
         case (which)
            0: hit = (status === 1'b1);
            1: hit = (clk_ext === 1'b1);
            2: hit = (done === 1'b1);
            default: hit = (locked === 1'b1);
         endcase
      end
      if (!hit) begin
         check_cnt(n, bound + 1, bound + 1);
         tally_and_finish();
      end
   endtask

   task automatic do_reset;
      srst_i = 1'b1;
      step(2);
      check_val({status, clk_ext, clk_hold, ts_active}, 8'h00);
      srst_i = 1'b0;
      falls = 0;
   endtask

   // Edge counts start after the request edge, so up to two extra edges above 1024 are allowed
   task automatic run_startup;
      wait_for(0, 12000, c);
      check_cnt(falls, 1024, 1026);
      check_val({clk_ext, clk_hold}, 8'h01);
      wait_for(1, 20, c);
      check_val({status, clk_hold, ts_active}, 8'h04);
   endtask

   initial begin
      seed = lfsr(seed);
      freq_sel = seed[3:0];
      powerup_timer_en = 1'b1;
      do_reset();
      step(20);
      check_val(ts_active, 8'h00);
      powerup_timer_done = 1'b1;
      falls = 0;
      step(3);
      check_val({ts_active, freq_o}, {1'b1, freq_sel});
      run_startup();
      $display("test startup done");
      sleep = 1'b1;
      ext_run = 1'b0;
      step(1);
      sleep = 1'b0;
      step(10);
      ext_run = 1'b1;
      wake = 1'b1;
      falls = 0;
      step(1);
      wake = 1'b0;
      step(2);
      check_val({status, clk_ext, ts_active}, 8'h01);
      step(200);
      sleep = 1'b1;
      ext_run = 1'b0;
      step(1);
      sleep = 1'b0;
      step(50);
      check_val(status, 8'h00);
      ext_run = 1'b1;
      wake = 1'b1;
      falls = 0;
      step(1);
      wake = 1'b0;
      run_startup();
      $display("test sleep done");
      powerup_timer_en = 1'b0;
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         cfg = i[3] ? 1'b0 : seed[0];
         fsm = i[3] ? i[0] : seed[1];
         sys_sel = i[3] ? 2'h0 : seed[3:2];
         osc_mode = i[2:0];
         freq_sel = seed[11:8];
         do_reset();
         step(4);
         check_val(ts_active, (cfg | fsm) & (sys_sel == 2'h0)
            & (osc_mode <= tsc_pkg::MODE_HIGH_SPEED_XTAL));
      end
      $display("test enable done");
      osc_mode = tsc_pkg::MODE_EXT_CLOCK;
      do_reset();
      for (int k = 0; k < 7; k++) begin
         // Align just after an external fall so edge counts are not shifted
         c = falls;
         for (int w = 0; w < 20 && falls == c; w++) begin
            step(1);
         end
         sw_from = sw_tab[k][0][2:0];
         sw_to = sw_tab[k][1][2:0];
         sw_req = 1'b1;
         step(1);
         sw_req = 1'b0;
         falls = 0;
         wait_for(2, 20000, c);
         if (sw_tab[k][2] != 0) begin
            check_cnt(falls, sw_tab[k][3] - 1, sw_tab[k][3]);
         end else begin
            check_cnt(c, sw_tab[k][3], sw_tab[k][3] + 1);
         end
         step(1);
      end
      $display("test switch done");
      pll_ok = 1'b1;
      pll_en = 1'b1;
      wait_for(3, 100, c);
      check_cnt(c, pll_cyc, pll_cyc + 2);
      pll_en = 1'b0;
      step(2);
      check_val(locked, 8'h00);
      pll_ok = 1'b0;
      pll_en = 1'b1;
      step(2);
      check_val(locked, 8'h01);
      pll_en = 1'b0;
      step(1);
      $display("test pll done");
      tally_and_finish();
   end
endmodule
